// ### hw/aof_formatter.sv
// sample output formatter: APB config, strap pins, link-side serializer
// assumes sample_i and encode_restart_i come from logic on link_clk_i, one sample per 8 cycles
//
// Design decisions made here: register access over APB and the register offsets.
module aof_formatter #(
    parameter int unsigned RELOCK_CYCLES = aof_pkg::DCS_RELOCK_CYCLES
) (
    // system
    input wire logic clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [aof_pkg::APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // strap pins
    input wire logic config_mode_select_i,
    input wire logic chip_select_pin_i,
    input wire logic serial_clock_pin_i,
    // link side
    input wire logic link_clk_i,
    input wire aof_pkg::aof_sample_t sample_i,
    input wire logic encode_restart_i,
    output logic [aof_pkg::SAMPLE_W-1:0] sample_bit_lines_o,
    output logic [aof_pkg::LANES-1:0] paired_bit_lanes_o,
    output logic forwarded_clock_true_o,
    output logic forwarded_clock_comp_o,
    output logic overrange_flag_o,
    output logic lvds_enable_o,
    output logic [2:0] lvds_current_o,
    output logic term_enable_o,
    output logic dcs_active_o
);
    import aof_pkg::*;

    localparam int CNT_W = $clog2(RELOCK_CYCLES + 1);

    typedef enum logic [1:0] {DCS_OFF, DCS_RELOCK, DCS_LOCKED} aof_dcs_t;

    function automatic logic [LANES-1:0] pick_bits(input logic [SAMPLE_W-1:0] w,
                                                   input logic odd);
        logic [LANES-1:0] r;
        r = '0;
        for (int k = 0; k < LANES; k++) begin
            r[k] = odd ? w[2*k+1] : w[2*k];
        end
        return r;
    endfunction

    // clk_i domain
    aof_cfg_t cfg_q;
    aof_cfg_t eff;
    aof_cfg_t xfer_word;
    logic req_tgl;
    logic ack_s1, ack_s2;
    logic lk_s1, lk_s2;
    logic par_s1, par_s2, cs_s1, cs_s2, sck_s1, sck_s2;
    logic setup, access, mapped;
    logic [31:0] ctrl_rd, stat_rd;

    // link domain
    logic lrst_s1, lrst_n;
    logic req_s1, req_s2, req_s3;
    aof_cfg_t lcfg, lcfg_pend;
    logic [2:0] ph, ph_n, ph_rel;
    logic [SAMPLE_W-1:0] word_q;
    logic of_q;
    logic next_fclk;
    logic ddr, lane_ddr;
    aof_dcs_t dcs_state, next_dcs_state;
    logic [CNT_W-1:0] rl_cnt, next_rl_cnt;
    logic locked_l;

    // pins and link status pass two flops before use
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            {par_s1, par_s2, cs_s1, cs_s2, sck_s1, sck_s2} <= 6'h00;
            {ack_s1, ack_s2, lk_s1, lk_s2} <= 4'h0;
        end else begin
            par_s1 <= config_mode_select_i;
            par_s2 <= par_s1;
            cs_s1 <= chip_select_pin_i;
            cs_s2 <= cs_s1;
            sck_s1 <= serial_clock_pin_i;
            sck_s2 <= sck_s1;
            ack_s1 <= req_s3;
            ack_s2 <= ack_s1;
            lk_s1 <= locked_l;
            lk_s2 <= lk_s1;
        end
    end

    always_comb begin
        eff = cfg_q;
        if (eff.mode > MODE_DDR_LVDS) begin
            eff.mode = MODE_FULL;
        end
        if (eff.lvds_cur > CUR_MAX) begin
            eff.lvds_cur = CUR_DEFAULT;
        end
        if (par_s2) begin
            // strapped mode has no way to pick DDR single-ended
            eff.mode = sck_s2 ? MODE_DDR_LVDS : MODE_FULL; // R16
            eff.dcs_en = cs_s2; // R13
            eff.phase = 2'h0;
            eff.invert = 1'b0;
            eff.lvds_cur = CUR_DEFAULT;
            eff.term_en = 1'b0;
        end
        // phase shifting relies on the stabilizer's clean clock
        if (!eff.dcs_en) begin
            eff.phase = 2'h0;
        end
        if (eff.mode != MODE_DDR_LVDS) begin
            eff.term_en = 1'b0; // R10
        end
    end

    // config word crosses by toggle handshake, word held while pending
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            xfer_word <= CFG_RESET;
            req_tgl <= 1'b0;
        end else if (req_tgl == ack_s2 && eff != xfer_word) begin
            xfer_word <= eff;
            req_tgl <= ~req_tgl;
        end
    end

    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i && pready_o;
    assign mapped = (paddr_i == ADDR_CTRL) || (paddr_i == ADDR_STATUS);

    always_comb begin
        ctrl_rd = '0;
        ctrl_rd[CTRL_MODE_LSB +: 2] = cfg_q.mode;
        ctrl_rd[CTRL_PHASE_LSB +: 2] = cfg_q.phase;
        ctrl_rd[CTRL_INV_BIT] = cfg_q.invert;
        ctrl_rd[CTRL_DCS_BIT] = cfg_q.dcs_en;
        ctrl_rd[CTRL_CUR_LSB +: 3] = cfg_q.lvds_cur;
        ctrl_rd[CTRL_TERM_BIT] = cfg_q.term_en;
        stat_rd = '0;
        stat_rd[STAT_LOCK_BIT] = lk_s2;
        stat_rd[STAT_PAR_BIT] = par_s2;
        stat_rd[STAT_MODE_LSB +: 2] = eff.mode;
        stat_rd[STAT_BUSY_BIT] = (req_tgl != ack_s2) || (eff != xfer_word);
    end

    // answer registered in setup, so every access has no wait state
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pready_o <= 1'b0;
            prdata_o <= '0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= setup;
            if (setup) begin
                pslverr_o <= !mapped;
                if (pwrite_i) begin
                    prdata_o <= '0;
                end else if (paddr_i == ADDR_CTRL) begin
                    prdata_o <= ctrl_rd;
                end else if (paddr_i == ADDR_STATUS) begin
                    prdata_o <= stat_rd;
                end else begin
                    prdata_o <= '0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RESET;
        end else if (access && pwrite_i && paddr_i == ADDR_CTRL) begin
            if (pstrb_i[0]) begin
                cfg_q.mode <= pwdata_i[CTRL_MODE_LSB +: 2]; // R1
                cfg_q.phase <= pwdata_i[CTRL_PHASE_LSB +: 2]; // R9
                cfg_q.invert <= pwdata_i[CTRL_INV_BIT];
                cfg_q.dcs_en <= pwdata_i[CTRL_DCS_BIT]; // R13
            end
            if (pstrb_i[1]) begin
                cfg_q.lvds_cur <= pwdata_i[CTRL_CUR_LSB +: 3]; // R10
                cfg_q.term_en <= pwdata_i[CTRL_TERM_BIT];
            end
        end
    end

    // link side
    always_ff @(posedge link_clk_i) begin
        lrst_s1 <= rst_n_i;
        lrst_n <= lrst_s1;
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            {req_s1, req_s2, req_s3} <= 3'h0;
            lcfg_pend <= CFG_RESET;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            if (req_s2 != req_s3) begin
                lcfg_pend <= xfer_word;
            end
        end
    end

    // new settings take effect only at a sample boundary
    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            lcfg <= CFG_RESET;
        end else if (ph == PH_LAST) begin
            lcfg <= lcfg_pend;
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            ph <= 3'h0;
            word_q <= '0;
            of_q <= 1'b0;
        end else begin
            ph <= ph_n;
            if (ph == PH_CAP) begin
                word_q <= sample_i.word; // R17
                of_q <= sample_i.overrange; // R15
            end
        end
    end

    assign ddr = (lcfg.mode == MODE_DDR_CMOS) || (lcfg.mode == MODE_DDR_LVDS);

    // counter phase gives a 4-of-8 high clock whatever the encode duty
    always_comb begin
        ph_n = ph + 3'h1;
        ph_rel = ph_n - {1'b0, lcfg.phase}; // R9
        next_fclk = (ph_rel >= PH_HALF) ^ lcfg.invert; // R11
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            forwarded_clock_true_o <= 1'b0;
            forwarded_clock_comp_o <= 1'b1;
        end else begin
            forwarded_clock_true_o <= next_fclk;
            forwarded_clock_comp_o <= !next_fclk; // R4
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            sample_bit_lines_o <= '0;
            paired_bit_lanes_o <= '0;
            overrange_flag_o <= 1'b0;
            lane_ddr <= 1'b0;
        end else if (ph == PH_LAST) begin // R3 R8
            overrange_flag_o <= of_q; // R5
            // odd half keeps its sample's format
            lane_ddr <= ddr;
            if (ddr) begin
                sample_bit_lines_o <= '0;
                paired_bit_lanes_o <= pick_bits(word_q, 1'b0); // R6
            end else begin
                sample_bit_lines_o <= word_q; // R2
                paired_bit_lanes_o <= '0;
            end
        end else if (ph == PH_MID && lane_ddr) begin // R8
            paired_bit_lanes_o <= pick_bits(word_q, 1'b1); // R7
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            lvds_enable_o <= 1'b0;
            lvds_current_o <= CUR_DEFAULT;
            term_enable_o <= 1'b0;
            dcs_active_o <= 1'b0;
        end else begin
            lvds_enable_o <= lcfg.mode == MODE_DDR_LVDS;
            lvds_current_o <= lcfg.lvds_cur;
            term_enable_o <= lcfg.term_en;
            dcs_active_o <= lcfg.dcs_en;
        end
    end

    // stabilizer relock tracking, counted in samples
    always_comb begin
        next_dcs_state = dcs_state;
        next_rl_cnt = rl_cnt;
        case (dcs_state)
            DCS_OFF: begin
                if (lcfg.dcs_en) begin
                    next_dcs_state = DCS_RELOCK;
                    next_rl_cnt = '0;
                end
            end
            DCS_RELOCK: begin
                if (!lcfg.dcs_en) begin
                    next_dcs_state = DCS_OFF;
                end else if (encode_restart_i) begin
                    next_rl_cnt = '0;
                end else if (ph == PH_LAST) begin
                    next_rl_cnt = rl_cnt + 1'b1;
                    if (rl_cnt == CNT_W'(RELOCK_CYCLES - 1)) begin
                        next_dcs_state = DCS_LOCKED; // R12
                    end
                end
            end
            DCS_LOCKED: begin
                if (!lcfg.dcs_en) begin
                    next_dcs_state = DCS_OFF;
                end else if (encode_restart_i) begin
                    next_dcs_state = DCS_RELOCK;
                    next_rl_cnt = '0;
                end
            end
            default: begin
                next_dcs_state = DCS_OFF;
            end
        endcase
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            dcs_state <= DCS_OFF;
            rl_cnt <= '0;
            locked_l <= 1'b1;
        end else begin
            dcs_state <= next_dcs_state;
            rl_cnt <= next_rl_cnt;
            locked_l <= next_dcs_state != DCS_RELOCK;
        end
    end

    sequence s_cap_show;
        (ph == PH_CAP) ##1 (ph == PH_LAST);
    endsequence

    property p_apb_ready;
        @(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && !penable_i) |=> pready_o ##1 !pready_o;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb ready not one cycle");

    property p_unmapped;
        @(posedge clk_i) disable iff (!rst_n_i)
        (psel_i && !penable_i && !mapped) |=> (pslverr_o && prdata_o == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_strap;
        @(posedge clk_i) disable iff (!rst_n_i)
        par_s2 |-> (eff.mode == (sck_s2 ? MODE_DDR_LVDS : MODE_FULL) && eff.dcs_en == cs_s2);
    endproperty
    a_strap: assert property (p_strap) else $error("strap decode wrong"); // R16 R13

    property p_full_bits;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (ph == PH_LAST && lcfg.mode == MODE_FULL) |=> sample_bit_lines_o == $past(word_q);
    endproperty
    a_full_bits: assert property (p_full_bits) else $error("full-rate word wrong"); // R2 R17

    property p_full_edge;
        @(posedge link_clk_i) disable iff (!lrst_n)
        ($changed(sample_bit_lines_o) && lcfg.phase == 2'h0 && !lcfg.invert && $stable(lcfg))
            |-> $fell(forwarded_clock_true_o);
    endproperty
    a_full_edge: assert property (p_full_edge) else $error("data not on falling edge"); // R3

    property p_ddr_edge;
        @(posedge link_clk_i) disable iff (!lrst_n)
        ($changed(paired_bit_lanes_o) && lcfg.phase == 2'h0 && !lcfg.invert && $stable(lcfg))
            |-> $changed(forwarded_clock_true_o);
    endproperty
    a_ddr_edge: assert property (p_ddr_edge) else $error("lane change off clock edge"); // R8

    property p_comp;
        @(posedge link_clk_i) disable iff (!rst_n_i || !lrst_n)
        forwarded_clock_comp_o == !forwarded_clock_true_o;
    endproperty
    a_comp: assert property (p_comp) else $error("complement clock wrong"); // R4

    property p_flag;
        @(posedge link_clk_i) disable iff (!lrst_n)
        s_cap_show |=> overrange_flag_o == $past(sample_i.overrange, 2);
    endproperty
    a_flag: assert property (p_flag) else $error("flag not aligned"); // R5 R15

    property p_ddr_lanes;
        @(posedge link_clk_i) disable iff (!lrst_n)
        (ph == PH_LAST && ddr) |=> paired_bit_lanes_o == pick_bits($past(word_q), 1'b0)
            ##4 paired_bit_lanes_o == pick_bits($past(word_q, 5), 1'b1);
    endproperty
    a_ddr_lanes: assert property (p_ddr_lanes) else $error("lane bits wrong"); // R6 R7

    property p_shift;
        @(posedge link_clk_i) disable iff (!lrst_n)
        ($rose(forwarded_clock_true_o) && !lcfg.invert && $stable(lcfg))
            |-> ph == PH_HALF + {1'b0, lcfg.phase};
    endproperty
    a_shift: assert property (p_shift) else $error("clock phase shift wrong"); // R9

    property p_duty;
        @(posedge link_clk_i) disable iff (!lrst_n)
        ($fell(forwarded_clock_true_o) && lcfg.dcs_en && lcfg == $past(lcfg, 8))
            |-> ($past(forwarded_clock_true_o, 2) && $past(forwarded_clock_true_o, 3)
            && $past(forwarded_clock_true_o, 4) && !$past(forwarded_clock_true_o, 5));
    endproperty
    a_duty: assert property (p_duty) else $error("clock duty not half"); // R11

    property p_relock;
        @(posedge link_clk_i) disable iff (!lrst_n)
        $rose(locked_l) && lcfg.dcs_en |-> rl_cnt == CNT_W'(RELOCK_CYCLES);
    endproperty
    a_relock: assert property (p_relock) else $error("relock too early"); // R12

    property p_term;
        @(posedge link_clk_i) disable iff (!lrst_n)
        term_enable_o |-> lvds_enable_o;
    endproperty
    a_term: assert property (p_term) else $error("termination outside lvds"); // R10

endmodule

// ### hw/aof_pkg.sv
// constants, field layouts and carrier types of the sample output formatter
// assumes an APB master in the clk_i domain and a link clock at the sample pin side
// Notes on behaviour
// [R1] three output formats: full-rate parallel, DDR single-ended, DDR differential, set by config
// [R2] full-rate drives twelve separate bit lines, highest line is the MSB
// [R3] full-rate data and flag change with forwarded clock falling edge when unshifted
// [R4] complementary forwarded clock is always the inverse of the true one
// [R5] overrange flag high for samples beyond top or bottom of range
// [R6] DDR formats use six lanes, lane k carries bits 2k and 2k+1
// [R7] DDR lane shows even bit while clock low, odd bit while high
// [R8] DDR lanes change on both clock edges when no shift is programmed
// [R9] forwarded clock can be delayed against data by a programmed phase
// [R10] differential DDR has programmable drive current and optional internal termination
// [R11] with stabilizer on, internal sample clock keeps fifty percent duty
// [R12] stabilizer needs one hundred encode cycles to relock after restart
// [R13] stabilizer enabled by register bit, or chip-select pin in strapped mode
// [R14] controller keeps stabilizer off below 5Msps or for fast rate changes
// [R15] overrange flag travels the same pipeline as its sample's data
// [R16] strapped mode: clock pin low full-rate, high differential DDR only
// [R17] sample and flag registered before serializing, lanes change on clock edges
package aof_pkg;

    localparam int SAMPLE_W = 12;
    localparam int LANES = 6;
    localparam int APB_AW = 12;

    // register byte addresses
    localparam logic [APB_AW-1:0] ADDR_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h004;

    // control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PHASE_LSB = 2;
    localparam int CTRL_INV_BIT = 4;
    localparam int CTRL_DCS_BIT = 5;
    localparam int CTRL_CUR_LSB = 8;
    localparam int CTRL_TERM_BIT = 12;

    // status register fields
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_PAR_BIT = 1;
    localparam int STAT_MODE_LSB = 2;
    localparam int STAT_BUSY_BIT = 4;

    // output formats
    localparam logic [1:0] MODE_FULL = 2'h0;
    localparam logic [1:0] MODE_DDR_CMOS = 2'h1;
    localparam logic [1:0] MODE_DDR_LVDS = 2'h2;

    // drive current codes 0..6 = 1.75, 2.1, 2.5, 3, 3.5, 4, 4.5 mA
    localparam logic [2:0] CUR_DEFAULT = 3'h4;
    localparam logic [2:0] CUR_MAX = 3'h6;

    // eight link cycles per sample, one per 45 degree step
    localparam logic [2:0] PH_MID = 3'h3;
    localparam logic [2:0] PH_HALF = 3'h4;
    localparam logic [2:0] PH_CAP = 3'h6;
    localparam logic [2:0] PH_LAST = 3'h7;

    // stabilizer relock, in encode cycles
    localparam int DCS_RELOCK_CYCLES = 100;

    typedef struct packed {
        logic term_en;
        logic [2:0] lvds_cur;
        logic dcs_en;
        logic invert;
        logic [1:0] phase;
        logic [1:0] mode;
    } aof_cfg_t;

    typedef struct packed {
        logic overrange;
        logic [SAMPLE_W-1:0] word;
    } aof_sample_t;

    localparam aof_cfg_t CFG_RESET = '{
        term_en: 1'b0, lvds_cur: CUR_DEFAULT, dcs_en: 1'b0,
        invert: 1'b0, phase: 2'h0, mode: MODE_FULL
    };

endpackage

// ### testbench/adc_sample_output_formatter_bench.sv
// bench for the sample output formatter: apb master, sample source, pin watcher
// assumes aof_pkg, aof_formatter and aof_rx_model are compiled before it
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module adc_sample_output_formatter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import aof_pkg::*;

    int mismatches = 0;
    int checked = 0;
    logic clk_i = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic pready, pslverr;
    logic [31:0] prdata, rd, rnd;
    logic er;
    logic strap = 1'b0, cs_pin = 1'b0, sck_pin = 1'b0, restart = 1'b0;
    aof_sample_t sample = '0, prev_s = '0, cur_s = '0, rx_full, rx_ddr;
    logic [SAMPLE_W-1:0] lines, lq;
    logic [LANES-1:0] lanes, pq;
    logic fwd, fwd_n, ovr, lvds_en, term_en, dcs_on, rx_valid, fell, rose;
    logic [2:0] cur;
    logic clkq = 1'b0, synced = 1'b0, chk = 1'b0, watch = 1'b0;
    logic [2:0] lph = 3'h0;
    logic [1:0] eff_mode = MODE_FULL;
    int gap = 0, rise_gap = 0, bad = 0, bad0 = 0;
    int seed = 32'h01c0;

    initial forever #25 clk_i = ~clk_i;
    initial begin
        #3.7;
        forever #3 link_clk = ~link_clk;
    end

    aof_formatter #(.RELOCK_CYCLES(100)) DUT (
        .clk_i(clk_i), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .config_mode_select_i(strap), .chip_select_pin_i(cs_pin),
        .serial_clock_pin_i(sck_pin), .link_clk_i(link_clk), .sample_i(sample),
        .encode_restart_i(restart), .sample_bit_lines_o(lines),
        .paired_bit_lanes_o(lanes), .forwarded_clock_true_o(fwd),
        .forwarded_clock_comp_o(fwd_n), .overrange_flag_o(ovr), .lvds_enable_o(lvds_en),
        .lvds_current_o(cur), .term_enable_o(term_en), .dcs_active_o(dcs_on));

    aof_rx_model RX (
        .link_clk_i(link_clk), .rst_n_i(rst_n), .sample_bit_lines_i(lines),
        .paired_bit_lanes_i(lanes), .forwarded_clock_true_i(fwd), .overrange_flag_i(ovr),
        .rx_valid_o(rx_valid), .rx_full_o(rx_full), .rx_ddr_o(rx_ddr));

    // source phase locks once to the first falling edge, then free-runs like the design
    always @(posedge link_clk) begin
        fell = clkq & ~fwd;
        rose = ~clkq & fwd;
        clkq <= fwd;
        lq <= lines;
        pq <= lanes;
        lph <= lph + 3'h1;
        if (!rst_n) begin
            synced <= 1'b0;
        end else if (!synced && fell) begin
            synced <= 1'b1;
            lph <= 3'h1;
        end
        if (synced && lph == 3'h1) begin
            rnd = $random(seed);
            sample <= rnd[12:0];
            prev_s <= cur_s;
            cur_s <= rnd[12:0];
        end
        if (synced) `CHK("comp clock", ~fwd, fwd_n)
        if (lq !== lines) gap <= 1;
        else gap <= gap + 1;
        if (rose) rise_gap <= gap;
        if (watch && ((lq !== lines && !fell) || (pq !== lanes && !fell && !rose))) begin
            bad <= bad + 1;
        end
        if (chk && rx_valid) begin
            if (eff_mode == MODE_FULL) begin
                `CHK("full word", prev_s, rx_full)
                `CHK("idle lanes", 6'h00, lanes)
            end else begin
                `CHK("ddr word", prev_s, rx_ddr)
                `CHK("idle lines", 12'h000, lines)
            end
        end
    end

    task automatic conclude();
        $display("counts: checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) `CHK("pready", 1'b1, pready)
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_ctrl(input logic [31:0] d);
        apb(1'b1, ADDR_CTRL, d, 4'hF);
    endtask

    task automatic rd_chk(input string nm, input logic [APB_AW-1:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'hF);
        `CHK(nm, e, rd)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    initial begin
        #150000;
        mismatches++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_n <= 1'b1;
        rd_chk("ctrl reset", ADDR_CTRL, 32'h0000_0400);
        rd_chk("status reset", ADDR_STATUS, 32'h0000_0001);
        apb(1'b1, 12'h008, 32'hFFFF_FFFF, 4'hF);
        `CHK("unmapped write err", 1'b1, er)
        rd_chk("unmapped read", 12'h008, 32'h0000_0000);
        `CHK("unmapped read err", 1'b1, er)
        apb(1'b1, ADDR_STATUS, 32'h0000_00FF, 4'hF);
        rd_chk("status kept", ADDR_STATUS, 32'h0000_0001);
        rd_chk("ctrl kept", ADDR_CTRL, 32'h0000_0400);
        $display("test register map done");
        for (int m = 0; m < 4; m++) begin
            wr_ctrl(32'h0000_0400 | m);
            eff_mode = (m == 3) ? MODE_FULL : 2'(m);
            settle(30);
            chk = 1'b1;
            watch = 1'b1;
            bad0 = bad;
            settle(40);
            chk = 1'b0;
            watch = 1'b0;
            `CHK("pins off clock edges", bad0, bad)
            `CHK("lvds enable", (m == 2), lvds_en)
            if (eff_mode == MODE_FULL) `CHK("rise gap", 4, rise_gap)
            $display("test format %0d done", m);
        end
        wr_ctrl(32'h0000_1602);
        settle(30);
        `CHK("drive current", 3'h6, cur)
        `CHK("termination on", 1'b1, term_en)
        apb(1'b1, ADDR_CTRL, 32'h0000_0000, 4'h1);
        settle(30);
        `CHK("termination off", 1'b0, term_en)
        rd_chk("ctrl byte write", ADDR_CTRL, 32'h0000_1600);
        $display("test lvds drive done");
        // encode rate here is well above 5Msps, so the stabilizer may be used
        wr_ctrl(32'h0000_0420);
        settle(20);
        `CHK("stabilizer on", 1'b1, dcs_on)
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, 4'hF);
        `CHK("relocking", 1'b0, rd[STAT_LOCK_BIT])
        settle(120);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, 4'hF);
        `CHK("locked", 1'b1, rd[STAT_LOCK_BIT])
        @(posedge link_clk);
        restart <= 1'b1;
        @(posedge link_clk);
        restart <= 1'b0;
        settle(20);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, 4'hF);
        `CHK("relock after restart", 1'b0, rd[STAT_LOCK_BIT])
        settle(120);
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, 4'hF);
        `CHK("locked again", 1'b1, rd[STAT_LOCK_BIT])
        $display("test stabilizer done");
        for (int k = 0; k < 4; k++) begin
            wr_ctrl(32'h0000_0420 | (k << CTRL_PHASE_LSB));
            settle(30);
            `CHK("shifted rise gap", 4 + k, rise_gap)
        end
        wr_ctrl(32'h0000_060C);
        settle(30);
        `CHK("shift without stabilizer", 4, rise_gap)
        `CHK("stabilizer off", 1'b0, dcs_on)
        wr_ctrl(32'h0000_0610);
        settle(30);
        `CHK("inverted rise gap", 8, rise_gap)
        $display("test clock phase done");
        // strapped mode only ever asks for full rate or differential ddr
        strap <= 1'b1;
        cs_pin <= 1'b1;
        sck_pin <= 1'b1;
        settle(30);
        `CHK("strap lvds", 1'b1, lvds_en)
        `CHK("strap stabilizer", 1'b1, dcs_on)
        `CHK("strap current", CUR_DEFAULT, cur)
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, 4'hF);
        `CHK("strap flag", 1'b1, rd[STAT_PAR_BIT])
        `CHK("strap mode", MODE_DDR_LVDS, rd[STAT_MODE_LSB+:2])
        sck_pin <= 1'b0;
        settle(30);
        `CHK("strap full", 1'b0, lvds_en)
        `CHK("strap rise gap", 4, rise_gap)
        apb(1'b0, ADDR_STATUS, 32'h0000_0000, 4'hF);
        `CHK("strap mode full", MODE_FULL, rd[STAT_MODE_LSB+:2])
        $display("test strapped mode done");
        conclude();
    end
endmodule

// ### testbench/aof_rx_model.sv
// far-side receiver model: captures word, flag and ddr lanes from the output pins
// assumes an unshifted forwarded clock; timing is reckoned from each falling edge
module aof_rx_model (
    // link side
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    input wire logic [aof_pkg::SAMPLE_W-1:0] sample_bit_lines_i,
    input wire logic [aof_pkg::LANES-1:0] paired_bit_lanes_i,
    input wire logic forwarded_clock_true_i,
    input wire logic overrange_flag_i,
    // captured sample
    output logic rx_valid_o,
    output aof_pkg::aof_sample_t rx_full_o,
    output aof_pkg::aof_sample_t rx_ddr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import aof_pkg::*;

    logic clk_q = 1'b0;
    logic [2:0] cnt = 3'h0;
    logic [LANES-1:0] even_q = '0;

    // sample mid-half, well away from the edges where the pins move
    always @(posedge link_clk_i) begin
        clk_q <= forwarded_clock_true_i;
        rx_valid_o <= 1'b0;
        if (!rst_n_i) begin
            cnt <= 3'h0;
            rx_full_o <= '0;
            rx_ddr_o <= '0;
        end else begin
            cnt <= (clk_q && !forwarded_clock_true_i) ? 3'h1 : cnt + 3'h1;
            if (cnt == 3'h2) begin
                rx_full_o <= '{overrange: overrange_flag_i, word: sample_bit_lines_i};
                rx_ddr_o.overrange <= overrange_flag_i;
                even_q <= paired_bit_lanes_i;
            end
            if (cnt == 3'h6) begin
                for (int k = 0; k < LANES; k++) begin
                    rx_ddr_o.word[2*k] <= even_q[k];
                    rx_ddr_o.word[2*k+1] <= paired_bit_lanes_i[k];
                end
                rx_valid_o <= 1'b1;
            end
        end
    end
endmodule
